/* File: ccsu_unit.sv */
// Purpose: Common command handling and standard status registers
// Assumes: One command at a time; answers leave as ASCII characters
// Notes:   Commands are only taken while the answer path is empty
`timescale 1ns/1ps
module ccsu_unit
	import ccsu_pkg::*;
#(
	parameter int unsigned                ID_LEN  = 16,
	// Arbitrary identification text, not a real part
	parameter logic [8*ID_LEN-1:0]        ID_TEXT = "MODEL,SN0,V1,D00"
)(
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	input  wire logic                     cmd_valid,
	input  wire ccsu_cmd_s                cmd,
	output logic                          cmd_ready,
	input  wire logic [7:0]               event_in,
	input  wire logic [7:0]               summary_in,
	output logic                          resp_valid,
	output ccsu_resp_s                    resp,
	input  wire logic                     resp_ready,
	output logic [7:0]                    status_byte,
	output logic                          remote_mode
);
	localparam int unsigned IW = (ID_LEN > 4) ? $clog2(ID_LEN) : 2;

	if (ID_LEN < 1) begin : g_bad_len
		$error("ID_LEN must be at least 1");
	end

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_NUM  = 2'b01,
		ST_TEXT = 2'b10
	} ccsu_state_e;

	ccsu_state_e   st_q, st_d;
	logic [7:0]    evt_q, evt_d;
	logic [7:0]    evm_q, evm_d;
	logic [7:0]    svm_q, svm_d;
	logic [7:0]    sbyte_q, sbyte_d;
	logic [1:0]    num_pos;
	logic [7:0]    val_q, val_d;
	logic [IW-1:0] idx_q, idx_d;
	logic          pend_q, pend_d;
	logic          rdy_q, rdy_d;
	logic          rv_q, rv_d;
	ccsu_resp_s    resp_q, resp_d;
	logic          rem_q, rem_d;
	logic [23:0]   digits;
	logic [1:0]    first;
	logic [7:0]    chr;
	logic          last;
	logic          take;

	ccsu_dec_fmt u_fmt (
		.value  (val_q),
		.digits (digits),
		.first  (first)
	);

	assign take = cmd_valid && rdy_q;

	always_comb begin
		// Leading zeros skipped by starting at the first significant digit
		num_pos = idx_q[1:0] + first;
		if (st_q == ST_TEXT) begin
			chr  = ID_TEXT[8*(ID_LEN-1-int'(idx_q)) +: 8];
			last = (int'(idx_q) == ID_LEN-1);
		end else begin
			chr  = digits[8*(2-int'(num_pos)) +: 8];
			last = (num_pos == 2'h2);
		end
	end

	always_comb begin
		st_d   = st_q;
		evt_d  = evt_q;
		evm_d  = evm_q;
		svm_d  = svm_q;
		val_d  = val_q;
		idx_d  = idx_q;
		pend_d = pend_q;
		rv_d   = rv_q;
		resp_d = resp_q;
		rem_d  = rem_q;
		case (st_q)
			ST_IDLE: begin
				if (take) begin
					pend_d = 1'b1;
					idx_d  = '0;
					case (cmd.op)
						OP_CLS:     evt_d = EVT_RESET;
						OP_EVM_SET: evm_d = cmd.arg;
						OP_SVM_SET: svm_d = cmd.arg & SVM_WRITE_MASK;
						OP_OPC_SET: evt_d[EVT_OPC_BIT] = 1'b1;
						OP_RST: begin
							evm_d = EVM_RESET;
							svm_d = SVM_RESET;
							rem_d = 1'b1;
						end
						OP_EVM_QRY: begin
							val_d = evm_q;
							st_d  = ST_NUM;
						end
						OP_EVT_QRY: begin
							val_d = evt_q;
							evt_d = EVT_RESET;
							st_d  = ST_NUM;
						end
						OP_OPC_QRY: begin
							val_d = OPC_DONE;
							st_d  = ST_NUM;
						end
						OP_SVM_QRY: begin
							val_d = svm_q;
							st_d  = ST_NUM;
						end
						OP_SBYTE_QRY: begin
							val_d = sbyte_q;
							st_d  = ST_NUM;
						end
						OP_TST_QRY: begin
							val_d = TST_PASS;
							st_d  = ST_NUM;
						end
						OP_IDN_QRY: st_d = ST_TEXT;
						default: ; // Wait is a no-op
					endcase
				end
			end
			default: begin
				if (!rv_q || resp_ready) begin
					if (pend_q) begin
						resp_d.chr  = chr;
						resp_d.last = last;
						rv_d        = 1'b1;
						pend_d      = !last;
						idx_d       = idx_q + 1'b1;
					end else begin
						rv_d = 1'b0;
						st_d = ST_IDLE;
					end
				end
			end
		endcase
		// New events win over any clear in the same cycle
		evt_d   = evt_d | event_in;
		rdy_d   = (st_d == ST_IDLE);
		sbyte_d = ccsu_sbyte(summary_in, evt_d, evm_d, svm_d, st_d != ST_IDLE);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q   <= ST_IDLE;
			evt_q  <= EVT_RESET;
			evm_q  <= EVM_RESET;
			svm_q  <= SVM_RESET;
			sbyte_q <= 8'h00;
			val_q  <= 8'h00;
			idx_q  <= '0;
			pend_q <= 1'b0;
			rdy_q  <= 1'b1;
			rv_q   <= 1'b0;
			resp_q <= '0;
			rem_q  <= 1'b0;
		end else begin
			st_q   <= st_d;
			evt_q  <= evt_d;
			evm_q  <= evm_d;
			svm_q  <= svm_d;
			sbyte_q <= sbyte_d;
			val_q  <= val_d;
			idx_q  <= idx_d;
			pend_q <= pend_d;
			rdy_q  <= rdy_d;
			rv_q   <= rv_d;
			resp_q <= resp_d;
			rem_q  <= rem_d;
		end
	end

	assign cmd_ready   = rdy_q;
	assign resp_valid  = rv_q;
	assign resp        = resp_q;
	assign status_byte = sbyte_q;
	assign remote_mode = rem_q;

	sequence s_take(ccsu_op_e o);
		cmd_valid && rdy_q && cmd.op == o;
	endsequence

	chk_cls_clears_esr: assert property (@(posedge ref_clk) disable iff (rst)
		s_take(OP_CLS) ##0 event_in == 8'h00 |=> evt_q == 8'h00)
		else $error("clear status left event bits set");
	chk_evm_mask_load: assert property (@(posedge ref_clk) disable iff (rst)
		s_take(OP_EVM_SET) |=> evm_q == $past(cmd.arg))
		else $error("event enable not loaded");
	chk_evt_read_clear: assert property (@(posedge ref_clk) disable iff (rst)
		s_take(OP_EVT_QRY) ##0 event_in == 8'h00 |=> evt_q == 8'h00)
		else $error("event status not cleared by read");
	chk_opc_sets_bit: assert property (@(posedge ref_clk) disable iff (rst)
		s_take(OP_OPC_SET) |=> evt_q[EVT_OPC_BIT])
		else $error("operation complete bit not set");
	chk_opc_query_one: assert property (@(posedge ref_clk) disable iff (rst)
		s_take(OP_OPC_QRY) |=> ##1 rv_q && resp_q.chr == ASCII_ONE && resp_q.last)
		else $error("operation complete query did not answer 1");
	chk_svm_bit_six: assert property (@(posedge ref_clk) disable iff (rst)
		!svm_q[SBYTE_MSS_BIT])
		else $error("service enable bit 6 set");
	chk_tst_answer_zero: assert property (@(posedge ref_clk) disable iff (rst)
		s_take(OP_TST_QRY) |=> ##1 rv_q && resp_q.chr == ASCII_ZERO && resp_q.last)
		else $error("self test did not answer 0");
	chk_rst_remote_defaults: assert property (@(posedge ref_clk) disable iff (rst)
		s_take(OP_RST) |=> rem_q && evm_q == EVM_RESET && svm_q == SVM_RESET)
		else $error("reset command did not restore defaults");
	chk_esb_summary_bit: assert property (@(posedge ref_clk) disable iff (rst)
		sbyte_q[SBYTE_ESB_BIT] == |(evt_q & evm_q))
		else $error("event summary bit wrong");
	chk_mss_summary_bit: assert property (@(posedge ref_clk) disable iff (rst)
		sbyte_q[SBYTE_MSS_BIT] == |({sbyte_q[7], 1'b0, sbyte_q[5:0]} & svm_q))
		else $error("master summary bit wrong");
endmodule : ccsu_unit

/* File: ccsu_pkg.sv */
// Purpose: Shared constants and types for the common command and status unit
// Assumes: Commands arrive already parsed, numeric arguments converted to binary
// Notes:   Bit positions follow the usual status byte layout
package ccsu_pkg;

	typedef enum logic [3:0] {
		OP_CLS     = 4'h0,
		OP_EVM_SET = 4'h1,
		OP_EVM_QRY = 4'h2,
		OP_EVT_QRY = 4'h3,
		OP_OPC_SET = 4'h4,
		OP_OPC_QRY = 4'h5,
		OP_SVM_SET = 4'h6,
		OP_SVM_QRY = 4'h7,
		OP_SBYTE_QRY = 4'h8,
		OP_TST_QRY = 4'h9,
		OP_WAI     = 4'hA,
		OP_RST     = 4'hB,
		OP_IDN_QRY = 4'hC
	} ccsu_op_e;

	typedef struct packed {
		ccsu_op_e   op;
		logic [7:0] arg;
	} ccsu_cmd_s;

	typedef struct packed {
		logic [7:0] chr;
		logic       last;
	} ccsu_resp_s;

	localparam int unsigned EVT_OPC_BIT    = 0;
	localparam int unsigned SBYTE_MAV_BIT  = 4;
	localparam int unsigned SBYTE_ESB_BIT  = 5;
	localparam int unsigned SBYTE_MSS_BIT  = 6;
	localparam logic [7:0]  SVM_WRITE_MASK = 8'hBF;
	localparam logic [7:0]  EVT_RESET      = 8'h00;
	localparam logic [7:0]  EVM_RESET      = 8'h00;
	localparam logic [7:0]  SVM_RESET      = 8'h00;
	localparam logic [7:0]  TST_PASS       = 8'h00;
	localparam logic [7:0]  OPC_DONE       = 8'h01;
	localparam logic [7:0]  ASCII_ZERO     = 8'h30;
	localparam logic [7:0]  ASCII_ONE      = 8'h31;

	// Status byte with the summary bit in position 6
	function automatic logic [7:0] ccsu_sbyte(input logic [7:0] summ, input logic [7:0] evt,
		input logic [7:0] evm, input logic [7:0] svm, input logic mav);
		logic [7:0] s;
		s = summ;
		s[SBYTE_MAV_BIT] = mav;
		s[SBYTE_ESB_BIT] = |(evt & evm);
		s[SBYTE_MSS_BIT] = 1'b0;
		s[SBYTE_MSS_BIT] = |(s & svm);
		return s;
	endfunction : ccsu_sbyte

endpackage : ccsu_pkg

/* File: ccsu_dec_fmt.sv */
// Purpose: Splits an 8 bit value into up to three ASCII decimal digits
// Assumes: Purely combinational, read by the answer sequencer
// Notes:   Leading zeros are skipped by the first digit index
`timescale 1ns/1ps
module ccsu_dec_fmt
	import ccsu_pkg::*;
(
	input  wire logic [7:0]  value,
	output logic      [23:0] digits,
	output logic      [1:0]  first
);
	logic [7:0] hund;
	logic [7:0] tens;
	logic [7:0] ones;

	assign hund   = value / 8'h64;
	assign tens   = (value / 8'h0A) % 8'h0A;
	assign ones   = value % 8'h0A;
	assign digits = {ASCII_ZERO + hund, ASCII_ZERO + tens, ASCII_ZERO + ones};
	assign first  = (hund != 8'h00) ? 2'h0 : ((tens != 8'h00) ? 2'h1 : 2'h2);
endmodule : ccsu_dec_fmt

/* File: ccsu_ctrl.sv */
// Purpose: Remote controller model on the command port
// Assumes: Answers are decimal digits or plain text
// Notes:   slow stalls resp_ready every other cycle
`timescale 1ns/1ps
module ccsu_ctrl
	import ccsu_pkg::*;
(
	input  wire logic       ref_clk,
	output logic            cmd_valid,
	output ccsu_cmd_s       cmd,
	input  wire logic       cmd_ready,
	input  wire logic       resp_valid,
	input  wire ccsu_resp_s resp,
	output logic            resp_ready,
	output logic            hung
);
	bit slow = 0;
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
		resp_ready = 1'b1;
		hung = 1'b0;
	end
	task automatic send(input ccsu_op_e op, input logic [7:0] arg);
		int n;
		n = 0;
		cmd_valid <= 1'b1;
		cmd <= '{op, arg};
		while (cmd_ready !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			#2;
			n++;
		end
		if (n >= 50)
			hung <= 1'b1;
		@(posedge ref_clk);
		#2;
		cmd_valid <= 1'b0;
		// Idle bus never repeats the last command
		cmd <= ~cmd;
	endtask : send
	task automatic query(input ccsu_op_e op, output int val, output int cnt);
		int n;
		val = 0;
		cnt = 0;
		n = 0;
		send(op, 8'h00);
		while (n < 200) begin
			n++;
			if (resp_valid === 1'b1 && resp_ready === 1'b1) begin
				val = val * 10 + int'(resp.chr) - 48;
				cnt++;
				if (resp.last === 1'b1)
					n = 999;
			end
			@(posedge ref_clk);
			#2;
			resp_ready <= (slow && n < 200) ? ~resp_ready : 1'b1;
		end
		if (n != 999)
			hung <= 1'b1;
	endtask : query
endmodule : ccsu_ctrl

/* File: test_common_command_status_unit.sv */
// Purpose: Self-checking bench for the command and status unit
// Assumes: Controller model drives the command port
// Notes:   Answers are parsed back to numbers before comparing
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module test_common_command_status_unit
	import ccsu_pkg::*;
;
	logic       ref_clk;
	logic       rst;
	logic       cmd_valid;
	ccsu_cmd_s  cmd;
	logic       cmd_ready;
	logic [7:0] event_in;
	logic [7:0] summary_in;
	logic       resp_valid;
	ccsu_resp_s resp;
	logic       resp_ready;
	logic [7:0] status_byte;
	logic       remote_mode;
	logic       hung;
	int         failures = 0;
	int         cmp_count = 0;
	int         v;
	int         c;
	ccsu_unit u_ccsu_unit (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .event_in(event_in), .summary_in(summary_in), .resp_valid(resp_valid),
		.resp(resp), .resp_ready(resp_ready), .status_byte(status_byte), .remote_mode(remote_mode));
	ccsu_ctrl u_ccsu_ctrl (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
		.resp_valid(resp_valid), .resp(resp), .resp_ready(resp_ready), .hung(hung));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic tick(int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask : tick
	task automatic s(ccsu_op_e op, logic [7:0] a);
		u_ccsu_ctrl.send(op, a);
	endtask : s
	task automatic q(ccsu_op_e op);
		u_ccsu_ctrl.query(op, v, c);
	endtask : q
	task automatic pulse(logic [7:0] e);
		event_in <= e;
		tick(1);
		event_in <= 8'h00;
		tick(1);
	endtask : pulse
	task automatic t_reset();
		`CHK(status_byte, 8'h00)
		`CHK(remote_mode, 1'b0)
		q(OP_EVM_QRY);
		`CHK(v, 0)
		$display("t_reset done");
	endtask : t_reset
	task automatic t_ese();
		s(OP_EVM_SET, 8'hFF);
		q(OP_EVM_QRY);
		`CHK(v, 255)
		s(OP_EVM_SET, 8'h5A);
		q(OP_EVM_QRY);
		`CHK(v, 90)
		$display("t_ese done");
	endtask : t_ese
	task automatic t_esr();
		pulse(8'h24);
		q(OP_EVT_QRY);
		`CHK(v, 36)
		q(OP_EVT_QRY);
		`CHK(v, 0)
		pulse(8'h80);
		s(OP_CLS, 8'h00);
		q(OP_EVT_QRY);
		`CHK(v, 0)
		s(OP_OPC_SET, 8'h00);
		q(OP_EVT_QRY);
		`CHK(v, 1)
		q(OP_OPC_QRY);
		`CHK(v * 10 + c, 11)
		$display("t_esr done");
	endtask : t_esr
	task automatic t_stb();
		u_ccsu_ctrl.slow = 1;
		s(OP_SVM_SET, 8'hFF);
		q(OP_SVM_QRY);
		`CHK(v, 191)
		u_ccsu_ctrl.slow = 0;
		s(OP_EVM_SET, 8'h01);
		s(OP_SVM_SET, 8'h20);
		pulse(8'h01);
		tick(2);
		`CHK(status_byte, 8'h60)
		q(OP_SBYTE_QRY);
		`CHK(v, 96)
		summary_in <= 8'h08;
		s(OP_SVM_SET, 8'h08);
		tick(3);
		`CHK(status_byte, 8'h68)
		summary_in <= 8'h00;
		$display("t_stb done");
	endtask : t_stb
	task automatic t_misc();
		q(OP_TST_QRY);
		`CHK(v * 10 + c, 1)
		s(OP_EVM_SET, 8'h33);
		s(OP_WAI, 8'h00);
		q(OP_EVM_QRY);
		`CHK(v, 51)
		s(OP_RST, 8'h00);
		tick(2);
		`CHK(remote_mode, 1'b1)
		q(OP_EVM_QRY);
		`CHK(v, 0)
		q(OP_IDN_QRY);
		`CHK(c, 16)
		$display("t_misc done");
	endtask : t_misc
	task automatic stop_test();
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	always @(posedge hung) begin
		failures++;
		stop_test();
	end
	initial begin
		rst = 1'b1;
		event_in = 8'h00;
		summary_in = 8'h00;
		tick(16);
		rst <= 1'b0;
		tick(1);
		t_reset();
		t_ese();
		t_esr();
		t_stb();
		t_misc();
		stop_test();
	end
endmodule : test_common_command_status_unit
